// ---- verilog/media_pcs_pkg.sv ----
// Constants shared by the media SerDes PCS register block
package media_pcs_pkg;

  localparam int ADDR_W   = 5;
  localparam int DATA_W   = 16;
  localparam int SERDES_W = 10;
  localparam int BYTE_W   = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 5'h17;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 5'h18;
  localparam logic [ADDR_W-1:0] ADV_ADDR  = 5'h19;

  // Control register fields
  localparam int CTRL_RF_HI      = 15;
  localparam int CTRL_RF_LO      = 14;
  localparam int CTRL_PAR_DET    = 13;
  localparam int CTRL_FORCE_ADV  = 11;
  localparam int CTRL_RX_POL     = 6;
  localparam int CTRL_TX_POL     = 5;
  localparam int CTRL_ODD_INH    = 4;
  localparam int CTRL_FORCE_HLS  = 2;
  localparam int CTRL_FORCE_FAR_END_FAULT_INDICATION = 1;
  localparam int CTRL_FAR_END_FAULT_INDICATION_VAL   = 0;

  // Status register fields
  localparam int ST_SYNC_FAIL  = 15;
  localparam int ST_CG_BAD     = 14;
  localparam int ST_LINK_100   = 13;
  localparam int ST_LINK_10    = 12;
  localparam int ST_LP_RESTART = 11;
  localparam int ST_RF_HI      = 9;
  localparam int ST_RF_LO      = 8;
  localparam int ST_LP_ASYM    = 7;
  localparam int ST_LP_SYM     = 6;
  localparam int ST_LP_FD      = 5;
  localparam int ST_LP_HD      = 4;
  localparam int ST_LP_AN_CAP  = 3;
  localparam int ST_LINK       = 2;
  localparam int ST_AN_DONE    = 1;
  localparam int ST_SIG_DET    = 0;

  // Reset values
  localparam logic              PAR_DET_RST    = 1'b0;
  localparam logic              FORCE_ADV_RST  = 1'b0;
  localparam logic              RX_POL_RST     = 1'b0;
  localparam logic              TX_POL_RST     = 1'b0;
  localparam logic              ODD_INH_RST    = 1'b1;
  localparam logic              FORCE_HLS_RST  = 1'b0;
  localparam logic              FORCE_FAR_END_FAULT_INDICATION_RST = 1'b0;
  localparam logic              FAR_END_FAULT_INDICATION_VAL_RST   = 1'b0;
  localparam logic [DATA_W-1:0] ADV_RST        = 16'h0000;

  localparam logic [BYTE_W-1:0] PREAMBLE_BYTE  = 8'h55;

  typedef enum logic [1:0] {
    st_idle,
    st_pass,
    st_drop,
    st_delay
  } odd_state_t;

endpackage : media_pcs_pkg

// ---- verilog/odd_start_align.sv ----
// Transmit byte path with odd-byte start handling
`timescale 1ns/1ps
module odd_start_align
  import media_pcs_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              inhibit,
  input  wire logic [BYTE_W-1:0] tx_byte_in,
  input  wire logic              tx_en_in,
  input  wire logic              tx_odd_in,
  output logic      [BYTE_W-1:0] tx_byte_out,
  output logic                   tx_en_out
);
  import media_pcs_pkg::*;
  default clocking assert_clk @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  odd_state_t        state_q;
  logic [BYTE_W-1:0] s1_byte_q;
  logic [BYTE_W-1:0] s2_byte_q;
  logic              s1_en_q;
  logic              s2_en_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s1_byte_q <= 8'h00;
      s2_byte_q <= 8'h00;
      s1_en_q   <= 1'b0;
      s2_en_q   <= 1'b0;
    end else begin
      s1_byte_q <= tx_byte_in;
      s1_en_q   <= tx_en_in;
      s2_byte_q <= s1_byte_q;
      s2_en_q   <= s1_en_q;
    end
  end

  // State describes the byte held in the first stage
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= st_idle;
    end else begin
      case (state_q)
        st_idle: begin
          if (tx_en_in && !tx_odd_in) begin
            state_q <= st_pass;
          end else if (tx_en_in && inhibit) begin
            state_q <= st_drop;
          end else if (tx_en_in) begin
            state_q <= st_delay;
          end
        end
        st_pass, st_drop: begin
          state_q <= tx_en_in ? st_pass : st_idle;
        end
        st_delay: begin
          if (!tx_en_in && !s1_en_q) begin
            state_q <= st_idle;
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_byte_out <= 8'h00;
      tx_en_out   <= 1'b0;
    end else if (state_q == st_delay) begin
      tx_byte_out <= s2_byte_q;
      tx_en_out   <= s2_en_q;
    end else begin
      tx_byte_out <= s1_byte_q;
      tx_en_out   <= s1_en_q && (state_q != st_drop);
    end
  end

  odd_drop_a: assert property (
    (state_q == st_idle && tx_en_in && tx_odd_in && inhibit)
    |-> ##2 !tx_en_out ##1 (tx_byte_out == $past(tx_byte_in, 2)))
    else $error("odd start byte not dropped");

  odd_delay_a: assert property (
    (state_q == st_idle && tx_en_in && tx_odd_in && !inhibit)
    |-> ##2 !tx_en_out ##1 (tx_en_out && tx_byte_out == $past(tx_byte_in, 3)))
    else $error("odd start packet not delayed");

  even_pass_a: assert property (
    (state_q == st_idle && tx_en_in && !tx_odd_in)
    |-> ##2 (tx_en_out && tx_byte_out == $past(tx_byte_in, 2)))
    else $error("even start packet mishandled");

endmodule : odd_start_align

// ---- verilog/media_serdes_pcs_regs.sv ----
// Media SerDes PCS control, status and advertised ability registers
`timescale 1ns/1ps
module media_serdes_pcs_regs
  import media_pcs_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [DATA_W-1:0]   reg_rdata,
  input  wire logic                an_enable,
  input  wire logic [1:0]          remote_fault_sent,
  input  wire logic [DATA_W-1:0]   generated_code_word,
  input  wire logic                sync_fail_evt,
  input  wire logic                cg_bad_evt,
  input  wire logic                link_100,
  input  wire logic                link_10,
  input  wire logic                lp_an_restart,
  input  wire logic [1:0]          lp_remote_fault,
  input  wire logic                lp_pause_asym,
  input  wire logic                lp_pause_sym,
  input  wire logic                lp_full_duplex,
  input  wire logic                lp_half_duplex,
  input  wire logic                lp_an_capable,
  input  wire logic                media_link,
  input  wire logic                an_complete,
  input  wire logic                signal_detect,
  input  wire logic                auto_far_end_fault_indication,
  input  wire logic [SERDES_W-1:0] serdes_rx_in,
  output logic      [SERDES_W-1:0] serdes_rx_out,
  input  wire logic [SERDES_W-1:0] serdes_tx_in,
  output logic      [SERDES_W-1:0] serdes_tx_out,
  input  wire logic [BYTE_W-1:0]   tx_byte_in,
  input  wire logic                tx_en_in,
  input  wire logic                tx_odd_in,
  output logic      [BYTE_W-1:0]   tx_byte_out,
  output logic                     tx_en_out,
  output logic                     parallel_detect_en,
  output logic      [DATA_W-1:0]   advertised_code_word,
  output logic                     halt_line_state,
  output logic                     far_end_fault_indication
);
  import media_pcs_pkg::*;
  default clocking assert_clk @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  function automatic logic [SERDES_W-1:0] pol_apply(
    input logic [SERDES_W-1:0] data,
    input logic                inv
  );
    pol_apply = inv ? ~data : data;
  endfunction : pol_apply

  logic              par_det_q;
  logic              force_adv_q;
  logic              rx_pol_q;
  logic              tx_pol_q;
  logic              odd_inh_q;
  logic              force_hls_q;
  logic              force_far_end_fault_indication_q;
  logic              far_end_fault_indication_val_q;
  logic [DATA_W-1:0] adv_q;
  logic              sync_fail_q;
  logic              cg_bad_q;
  logic              sync_fail_d;
  logic              cg_bad_d;
  logic              wr_ctrl;
  logic              wr_adv;
  logic              rd_stat;
  logic [DATA_W-1:0] ctrl_val;
  logic [DATA_W-1:0] stat_val;
  logic [DATA_W-1:0] adv_val;
  logic [DATA_W-1:0] rdata_d;

  assign wr_ctrl = reg_wr && (reg_addr == CTRL_ADDR);
  assign wr_adv  = reg_wr && (reg_addr == ADV_ADDR) && force_adv_q;
  assign rd_stat = reg_rd && (reg_addr == STAT_ADDR);

  // Control register writable bits
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      par_det_q    <= PAR_DET_RST;
      force_adv_q  <= FORCE_ADV_RST;
      rx_pol_q     <= RX_POL_RST;
      tx_pol_q     <= TX_POL_RST;
      odd_inh_q    <= ODD_INH_RST;
      force_hls_q  <= FORCE_HLS_RST;
      force_far_end_fault_indication_q <= FORCE_FAR_END_FAULT_INDICATION_RST;
      far_end_fault_indication_val_q   <= FAR_END_FAULT_INDICATION_VAL_RST;
    end else if (wr_ctrl) begin
      par_det_q    <= reg_wdata[CTRL_PAR_DET];
      force_adv_q  <= reg_wdata[CTRL_FORCE_ADV];
      rx_pol_q     <= reg_wdata[CTRL_RX_POL];
      tx_pol_q     <= reg_wdata[CTRL_TX_POL];
      odd_inh_q    <= reg_wdata[CTRL_ODD_INH];
      force_hls_q  <= reg_wdata[CTRL_FORCE_HLS];
      force_far_end_fault_indication_q <= reg_wdata[CTRL_FORCE_FAR_END_FAULT_INDICATION];
      far_end_fault_indication_val_q   <= reg_wdata[CTRL_FAR_END_FAULT_INDICATION_VAL];
    end
  end

  // Advertised ability register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      adv_q <= ADV_RST;
    end else if (wr_adv) begin
      adv_q <= reg_wdata;
    end
  end

  assign sync_fail_d = sync_fail_evt || (sync_fail_q && !rd_stat);
  assign cg_bad_d    = cg_bad_evt || (cg_bad_q && !rd_stat);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync_fail_q <= 1'b0;
    end else begin
      sync_fail_q <= sync_fail_d;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cg_bad_q <= 1'b0;
    end else begin
      cg_bad_q <= cg_bad_d;
    end
  end

  // Register read values
  always_comb begin
    ctrl_val                  = 16'h0000;
    ctrl_val[CTRL_RF_HI]      = remote_fault_sent[1];
    ctrl_val[CTRL_RF_LO]      = remote_fault_sent[0];
    ctrl_val[CTRL_PAR_DET]    = par_det_q;
    ctrl_val[CTRL_FORCE_ADV]  = force_adv_q;
    ctrl_val[CTRL_RX_POL]     = rx_pol_q;
    ctrl_val[CTRL_TX_POL]     = tx_pol_q;
    ctrl_val[CTRL_ODD_INH]    = odd_inh_q;
    ctrl_val[CTRL_FORCE_HLS]  = force_hls_q;
    ctrl_val[CTRL_FORCE_FAR_END_FAULT_INDICATION] = force_far_end_fault_indication_q;
    ctrl_val[CTRL_FAR_END_FAULT_INDICATION_VAL]   = far_end_fault_indication_val_q;
  end

  always_comb begin
    stat_val                = 16'h0000;
    stat_val[ST_SYNC_FAIL]  = sync_fail_q;
    stat_val[ST_CG_BAD]     = cg_bad_q;
    stat_val[ST_LINK_100]   = link_100;
    stat_val[ST_LINK_10]    = link_10;
    stat_val[ST_LP_RESTART] = lp_an_restart;
    stat_val[ST_RF_HI]      = lp_remote_fault[1];
    stat_val[ST_RF_LO]      = lp_remote_fault[0];
    stat_val[ST_LP_ASYM]    = lp_pause_asym;
    stat_val[ST_LP_SYM]     = lp_pause_sym;
    stat_val[ST_LP_FD]      = lp_full_duplex;
    stat_val[ST_LP_HD]      = lp_half_duplex;
    stat_val[ST_LP_AN_CAP]  = lp_an_capable;
    stat_val[ST_LINK]       = media_link;
    stat_val[ST_AN_DONE]    = an_complete;
    stat_val[ST_SIG_DET]    = signal_detect;
  end

  assign adv_val = force_adv_q ? adv_q : generated_code_word;

  always_comb begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        CTRL_ADDR: rdata_d = ctrl_val;
        STAT_ADDR: rdata_d = stat_val;
        ADV_ADDR:  rdata_d = adv_val;
        default:   rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // Media facing controls
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      advertised_code_word <= ADV_RST;
    end else begin
      advertised_code_word <= adv_val;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      parallel_detect_en <= 1'b0;
    end else begin
      parallel_detect_en <= par_det_q && an_enable;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      halt_line_state <= 1'b0;
    end else begin
      halt_line_state <= force_hls_q;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      far_end_fault_indication <= 1'b0;
    end else if (force_far_end_fault_indication_q) begin
      far_end_fault_indication <= far_end_fault_indication_val_q;
    end else begin
      far_end_fault_indication <= auto_far_end_fault_indication;
    end
  end

  // SerDes data polarity
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      serdes_rx_out <= 10'h000;
      serdes_tx_out <= 10'h000;
    end else begin
      serdes_rx_out <= pol_apply(serdes_rx_in, rx_pol_q);
      serdes_tx_out <= pol_apply(serdes_tx_in, tx_pol_q);
    end
  end

  // Odd start transmit alignment
  odd_start_align u_odd_start_align (
    .ref_clk     (ref_clk),
    .resetn      (resetn),
    .inhibit     (odd_inh_q),
    .tx_byte_in  (tx_byte_in),
    .tx_en_in    (tx_en_in),
    .tx_odd_in   (tx_odd_in),
    .tx_byte_out (tx_byte_out),
    .tx_en_out   (tx_en_out)
  );

  rf_sent_a: assert property (
    (reg_rd && reg_addr == CTRL_ADDR)
    |=> (reg_rdata[15:14] == $past(remote_fault_sent)))
    else $error("remote fault sent field wrong");

  par_det_a: assert property (
    (wr_ctrl && reg_wdata[CTRL_PAR_DET] && an_enable) ##1 an_enable
    |=> parallel_detect_en)
    else $error("parallel detect not enabled");

  par_gate_a: assert property (
    !an_enable |=> !parallel_detect_en)
    else $error("parallel detect without autoneg");

  adv_force_a: assert property (
    (reg_wr && reg_addr == ADV_ADDR && force_adv_q) ##1 force_adv_q
    |=> (advertised_code_word == $past(reg_wdata, 2)))
    else $error("forced code word not advertised");

  rx_pol_a: assert property (
    rx_pol_q |=> (serdes_rx_out == ~$past(serdes_rx_in)))
    else $error("receive polarity not inverted");

  tx_pol_a: assert property (
    !tx_pol_q |=> (serdes_tx_out == $past(serdes_tx_in)))
    else $error("transmit data altered");

  hls_out_a: assert property (
    force_hls_q [*2] |-> halt_line_state)
    else $error("halt line state not sent");

  far_end_fault_indication_force_a: assert property (
    force_far_end_fault_indication_q |=> (far_end_fault_indication == $past(far_end_fault_indication_val_q)))
    else $error("forced fault value not followed");

  far_end_fault_indication_auto_a: assert property (
    !force_far_end_fault_indication_q |=> (far_end_fault_indication == $past(auto_far_end_fault_indication)))
    else $error("automatic fault indication lost");

  sync_flag_a: assert property (
    sync_fail_evt ##1 (reg_rd && reg_addr == STAT_ADDR)
    |=> reg_rdata[ST_SYNC_FAIL])
    else $error("sync failure not reported");

  cg_flag_a: assert property (
    cg_bad_evt ##1 (reg_rd && reg_addr == STAT_ADDR)
    |=> reg_rdata[ST_CG_BAD])
    else $error("bad code-group not reported");

  link_stat_a: assert property (
    (reg_rd && reg_addr == STAT_ADDR)
    |=> (reg_rdata[13:11] == $past({link_100, link_10, lp_an_restart})))
    else $error("link or restart status wrong");

  lp_stat_a: assert property (
    (reg_rd && reg_addr == STAT_ADDR)
    |=> (reg_rdata[9:0] == $past({lp_remote_fault, lp_pause_asym,
         lp_pause_sym, lp_full_duplex, lp_half_duplex, lp_an_capable,
         media_link, an_complete, signal_detect})))
    else $error("partner status wrong");

  adv_lock_a: assert property (
    (reg_wr && reg_addr == ADV_ADDR && !force_adv_q)
    |=> (adv_q == $past(adv_q)))
    else $error("advertised word written while unforced");

  clr_read_a: assert property (
    (rd_stat && !sync_fail_evt && !cg_bad_evt) ##1
    (!sync_fail_evt && !cg_bad_evt)
    |=> (!sync_fail_q && !cg_bad_q))
    else $error("sticky flags not cleared by read");

  set_wins_a: assert property (
    (rd_stat && sync_fail_evt) |=> sync_fail_q)
    else $error("event lost on clearing read");

endmodule : media_serdes_pcs_regs

// ---- verification/media_link_partner.sv ----
// Fiber link partner model: abilities, error events and receive data
`timescale 1ns/1ps
module media_link_partner (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [15:0] lp_word,
  input  wire logic        req_sf,
  input  wire logic        req_cg,
  output logic             sync_fail_evt,
  output logic             cg_bad_evt,
  output logic             lp_an_restart,
  output logic [1:0]       lp_remote_fault,
  output logic [3:0]       lp_abil,
  output logic             lp_an_capable,
  output logic [9:0]       serdes_rx_in
);
  // Abilities follow the status layout of the word
  assign lp_an_restart   = lp_word[11];
  assign lp_remote_fault = lp_word[9:8];
  assign lp_abil         = lp_word[7:4];
  assign lp_an_capable   = lp_word[3];

  // One-cycle events; receive data changes every cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync_fail_evt <= 1'b0;
      cg_bad_evt    <= 1'b0;
      serdes_rx_in  <= 10'h155;
    end else begin
      sync_fail_evt <= req_sf;
      cg_bad_evt    <= req_cg;
      serdes_rx_in  <= serdes_rx_in + 10'h13B;
    end
  end
endmodule : media_link_partner

// ---- verification/media_serdes_pcs_regs_test.sv ----
// Testbench for the media SerDes PCS register block
`timescale 1ns/1ps
module test_media_serdes_pcs_regs;
  import media_pcs_pkg::*;
  logic              ref_clk = 1'b0;
  logic              resetn = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata, advertised_code_word;
  logic              an_enable = 1'b0;
  logic              auto_far_end_fault_indication = 1'b0;
  logic [15:0]       lvl = '0;
  logic [15:0]       lp_word = '0;
  logic              req_sf = 1'b0;
  logic              req_cg = 1'b0;
  logic [7:0]        tx_byte_in = '0;
  logic              tx_en_in = 1'b0;
  logic              tx_odd_in = 1'b0;
  logic [7:0]        tx_byte_out, last_out;
  logic [9:0]        serdes_rx_in, serdes_rx_out, serdes_tx_out, rx_prev;
  logic [3:0]        lp_abil;
  logic [1:0]        lp_remote_fault;
  logic              sync_fail_evt, cg_bad_evt, lp_an_restart, lp_an_capable;
  logic              tx_en_out, parallel_detect_en, halt_line_state;
  logic              far_end_fault_indication, en_prev;
  int                errors = 0;
  int                checked = 0;
  int                cyc = 0;
  int                in_cyc, out_cyc, n_out;
  logic [15:0]       lpw [3] = '{16'h0AA8, 16'h0150, 16'h0BF8};
  logic [15:0]       lvw [3] = '{16'h2005, 16'h1002, 16'h3007};
  logic [15:0]       flw [3] = '{16'h8000, 16'h4000, 16'hC000};

  always #2 ref_clk = ~ref_clk;

  media_link_partner i_partner (
    .ref_clk(ref_clk), .resetn(resetn), .lp_word(lp_word),
    .req_sf(req_sf), .req_cg(req_cg), .sync_fail_evt(sync_fail_evt),
    .cg_bad_evt(cg_bad_evt), .lp_an_restart(lp_an_restart),
    .lp_remote_fault(lp_remote_fault), .lp_abil(lp_abil),
    .lp_an_capable(lp_an_capable), .serdes_rx_in(serdes_rx_in));

  media_serdes_pcs_regs i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .an_enable(an_enable),
    .remote_fault_sent(2'b10), .generated_code_word(16'h41A0),
    .sync_fail_evt(sync_fail_evt), .cg_bad_evt(cg_bad_evt),
    .link_100(lvl[13]), .link_10(lvl[12]), .lp_an_restart(lp_an_restart),
    .lp_remote_fault(lp_remote_fault), .lp_pause_asym(lp_abil[3]),
    .lp_pause_sym(lp_abil[2]), .lp_full_duplex(lp_abil[1]),
    .lp_half_duplex(lp_abil[0]), .lp_an_capable(lp_an_capable),
    .media_link(lvl[2]), .an_complete(lvl[1]), .signal_detect(lvl[0]),
    .auto_far_end_fault_indication(auto_far_end_fault_indication), .serdes_rx_in(serdes_rx_in),
    .serdes_rx_out(serdes_rx_out), .serdes_tx_in(10'h2A5),
    .serdes_tx_out(serdes_tx_out), .tx_byte_in(tx_byte_in),
    .tx_en_in(tx_en_in), .tx_odd_in(tx_odd_in), .tx_byte_out(tx_byte_out),
    .tx_en_out(tx_en_out), .parallel_detect_en(parallel_detect_en),
    .advertised_code_word(advertised_code_word),
    .halt_line_state(halt_line_state),
    .far_end_fault_indication(far_end_fault_indication));

  // Transmit monitor, receive history and cycle ceiling
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    rx_prev <= serdes_rx_in;
    en_prev <= tx_en_in;
    if (tx_en_in && !en_prev) in_cyc <= cyc;
    if (tx_en_out === 1'b1) begin
      if (n_out == 0) out_cyc <= cyc;
      n_out <= n_out + 1;
      last_out <= tx_byte_out;
    end
    if (cyc == 3000) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e,
                    input string n);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(n, e, reg_rdata);
  endtask : rd

  task automatic settle();
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle

  task automatic pkt(input logic odd, input int lat, input int cnt);
    logic [7:0] b [4] = '{8'h55, 8'h55, 8'hD5, 8'h3C};
    n_out = 0;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      tx_en_in   <= 1'b1;
      tx_odd_in  <= odd;
      tx_byte_in <= b[i];
    end
    @(posedge ref_clk);
    tx_en_in  <= 1'b0;
    tx_odd_in <= 1'b0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("tx latency", 16'(lat), 16'(out_cyc - in_cyc));
    chk("tx count", 16'(cnt), 16'(n_out));
    chk("tx last byte", 16'h003C, {8'h00, last_out});
    $display("test transmit packet odd=%0d done", odd);
  endtask : pkt

  initial begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(CTRL_ADDR, 16'h8010,
       "ctrl reset");
    wr(ADV_ADDR, 16'h1234);
    wr(CTRL_ADDR, 16'h0810);
    rd(ADV_ADDR, 16'h0000, "adv reset");
    wr(ADV_ADDR, 16'hA5C3);
    rd(ADV_ADDR, 16'hA5C3, "adv written");
    settle();
    chk("adv forced", 16'hA5C3, advertised_code_word);
    wr(CTRL_ADDR, 16'h2010);
    settle();
    chk("adv generated", 16'h41A0, advertised_code_word);
    chk("pd without autoneg", 16'h0000, 16'(parallel_detect_en));
    // Autoneg on while the generated word offers full duplex
    @(posedge ref_clk);
    an_enable <= 1'b1;
    settle();
    chk("pd with autoneg", 16'h0001, 16'(parallel_detect_en));
    $display("test advertise and detect done");
    for (int p = 0; p < 4; p++) begin
      wr(CTRL_ADDR, 16'h2010 | 16'(p << 5));
      settle();
      chk("rx data", 16'(rx_prev ^ {10{p[1]}}), 16'(serdes_rx_out));
      chk("tx data", 16'(10'h2A5 ^ {10{p[0]}}), 16'(serdes_tx_out));
      rd(CTRL_ADDR, 16'hA010 | 16'(p << 5), "ctrl pol");
    end
    $display("test polarity done");
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      auto_far_end_fault_indication <= i[3];
      wr(CTRL_ADDR, 16'h2010 | 16'(i[2:0]));
      settle();
      chk("hls", 16'(i[2]), 16'(halt_line_state));
      chk("far_end_fault_indication", 16'(i[1] ? i[0] : i[3]),
          16'(far_end_fault_indication));
    end
    $display("test fx line state done");
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      lp_word <= lpw[k];
      lvl     <= lvw[k];
      req_sf  <= flw[k][15];
      req_cg  <= flw[k][14];
      @(posedge ref_clk);
      req_sf <= 1'b0;
      req_cg <= 1'b0;
      rd(STAT_ADDR, lpw[k] | lvw[k] | flw[k],
         "status");
      rd(STAT_ADDR, lpw[k] | lvw[k], "status cleared");
    end
    rd(5'h05, 16'h0000, "unmapped");
    wr(STAT_ADDR, 16'hFFFF);
    rd(STAT_ADDR, lpw[2] | lvw[2], "status read only");
    // Sync failure event in the same cycle as a clearing read
    @(posedge ref_clk);
    req_sf <= 1'b1;
    @(posedge ref_clk);
    req_sf   <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= STAT_ADDR;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk("status racing event", lpw[2] | lvw[2], reg_rdata);
    rd(STAT_ADDR, lpw[2] | lvw[2] | 16'h8000, "event kept");
    $display("test status done");
    pkt(1'b0, 2, 4);
    pkt(1'b1, 3, 3);
    wr(CTRL_ADDR, 16'h2000);
    pkt(1'b1, 3, 4);
    summarize();
  end
endmodule : test_media_serdes_pcs_regs
